// [hdl/up_counter_reload_compare.sv]
// Purpose: 16-bit prescaled up counter, auto-reload or compare, with capture
// Assumes: capture events are one-cycle pulses from logic on sys_clk
// Notes:   registers reached over AHB-Lite, byte data in the low bits
// Function
// - sixteen bit counter, bytes separately readable, writable
// - prescaler divides by 1..512 per code
// - run bit gates counting, stop keeps count
// - mode bit zero selects reload or compare
// - event flag set on overflow or match
// - event flag cleared only by software
// - interrupt when flag, local, global enables set
// - reload only while reload enable bit set
// - trigger select overflow or capture channel
// - reload mode capture clears count when enabled
// - compare mode match clears count when enabled
// - low byte is compare or reload low
// - three capture pairs load count on event
// - separate high byte register resets zero
// - match when all count bytes equal compare
// - capture clear suppresses reload, clears only
//
// Design decision made here: the AHB-Lite interface to the registers.
`timescale 1ns/10ps

module up_counter_reload_compare
   import ctr_pkg::*;
(
   input  wire logic        sys_clk,   // system clock, 100 MHz
   input  wire logic        rst_b,     // asynchronous reset, active low
   input  wire logic        hsel,      // slave select
   input  wire logic [31:0] haddr,     // byte address
   input  wire logic [1:0]  htrans,    // transfer type
   input  wire logic        hwrite,    // write when high
   input  wire logic [2:0]  hsize,     // word transfers only
   input  wire logic [31:0] hwdata,    // write data, data phase
   input  wire logic        hready,    // bus ready in
   output logic      [31:0] hrdata,    // read data, from flops
   output logic             hreadyout, // slave ready
   output logic             hresp,     // always okay
   input  wire logic [2:0]  cap_event, // capture event pulses
   output logic             irq        // level interrupt
);

   // ************************************************************
   // state
   // ************************************************************
   bus_req_t    req_q;                  // latched address phase
   logic        rd_wait_q;              // read wait state pending
   logic [31:0] hrdata_q;               // read data holder
   logic        flag_q;                 // counter_event_flag
   logic        run_q;                  // counter_run_bit
   logic        cmp_mode_q;             // compare_reload_select
   mode_t       mode_q;                 // counter_mode_setup
   logic [7:0]  rcmp_low_q;             // reload_compare_low
   logic [7:0]  rcmp_high_q;            // reload_compare_high
   logic [15:0] count_q;                // count_high_byte:count_low_byte
   logic [15:0] count_d;                // next count
   logic [8:0]  pre_cnt_q;              // prescaler count
   logic [15:0] cap_q [NUM_CAP];        // capture results
   logic [2:0]  cap_st_q;               // sticky capture status
   logic [3:0]  mask_q;                 // local interrupt enables
   logic        global_q;               // global interrupt enable
   logic        tick;                   // prescaled count strobe
   logic        ovf;                    // overflow this tick
   logic        match;                  // compare match this tick
   logic        wr_en;                  // data phase of a write
   logic [15:0] reload_val;             // high:low reload/compare
   logic [7:0]  rd_mux;                 // selected register byte
   logic [7:0]  wb;                     // written byte

   assign hresp     = 1'b0;             // every transfer answers okay
   assign hreadyout = !rd_wait_q;       // reads take one wait state
   assign hrdata    = hrdata_q;
   assign wr_en     = req_q.valid && req_q.wr && req_q.hit;
   assign wb        = hwdata[7:0];
   assign reload_val = {rcmp_high_q, rcmp_low_q};

   // ************************************************************
   // bus slave
   // ************************************************************

   // address phase capture; hsize unused since only words arrive
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         req_q <= '0;
      end else if (hready) begin
         req_q.valid <= hsel && htrans[1];
         req_q.wr    <= hwrite;
         req_q.hit   <= (haddr[31:10] == 22'h000000) && (haddr[1:0] == 2'b00);
         req_q.idx   <= haddr[9:2];
      end
   end

   // read byte selection, unmapped reads give zero
   always_comb begin
      rd_mux = 8'h00;
      unique case (req_q.idx)
         IDX_CONTROL:      rd_mux = {flag_q, 4'h0, run_q, 1'b0, cmp_mode_q};
         IDX_MODE:         rd_mux = mode_q;
         IDX_RCMP_LOW:     rd_mux = rcmp_low_q;
         IDX_RCMP_HIGH:    rd_mux = rcmp_high_q;
         IDX_COUNT_LOW:    rd_mux = count_q[7:0];
         IDX_COUNT_HIGH:   rd_mux = count_q[15:8];
         IDX_CAP_BASE:     rd_mux = cap_q[0][7:0];
         IDX_CAP_BASE + 8'h01: rd_mux = cap_q[0][15:8];
         IDX_CAP_BASE + 8'h02: rd_mux = cap_q[1][7:0];
         IDX_CAP_BASE + 8'h03: rd_mux = cap_q[1][15:8];
         IDX_CAP_BASE + 8'h04: rd_mux = cap_q[2][7:0];
         IDX_CAP_BASE + 8'h05: rd_mux = cap_q[2][15:8];
         IDX_IRQ_STATUS:   rd_mux = {4'h0, cap_st_q, flag_q};
         IDX_IRQ_MASK:     rd_mux = {4'h0, mask_q};
         IDX_IRQ_GLOBAL:   rd_mux = {7'h00, global_q};
         default:          rd_mux = 8'h00;
      endcase
   end

   // read data one cycle after the address phase, so a write just before lands first
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         rd_wait_q <= 1'b0;
         hrdata_q  <= 32'h00000000;
      end else if (rd_wait_q) begin
         rd_wait_q <= 1'b0;
         hrdata_q  <= req_q.hit ? {24'h000000, rd_mux} : 32'h00000000;
      end else begin
         rd_wait_q <= hready && hsel && htrans[1] && !hwrite;
      end
   end

   // ************************************************************
   // configuration registers
   // ************************************************************

   // run, mode and reload/compare bytes, all zero after reset
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         run_q       <= 1'b0;
         cmp_mode_q  <= 1'b0;
         mode_q      <= RESET_BYTE;
         rcmp_low_q  <= RESET_BYTE;
         rcmp_high_q <= RESET_BYTE;
         mask_q      <= 4'h0;
         global_q    <= 1'b0;
      end else if (wr_en) begin
         if (req_q.idx == IDX_CONTROL) begin
            run_q      <= wb[CTL_RUN_BIT];
            cmp_mode_q <= wb[CTL_MODE_BIT];
         end
         if (req_q.idx == IDX_MODE)       mode_q      <= wb;
         if (req_q.idx == IDX_RCMP_LOW)   rcmp_low_q  <= wb;
         if (req_q.idx == IDX_RCMP_HIGH)  rcmp_high_q <= wb;
         if (req_q.idx == IDX_IRQ_MASK)   mask_q      <= wb[3:0];
         if (req_q.idx == IDX_IRQ_GLOBAL) global_q    <= wb[0];
      end
   end

   // ************************************************************
   // prescaler
   // ************************************************************

   // restarts on a mode write so a smaller ratio never waits for wrap
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         pre_cnt_q <= 9'h000;
      end else if (!run_q || tick || (wr_en && req_q.idx == IDX_MODE)) begin
         pre_cnt_q <= 9'h000;
      end else begin
         pre_cnt_q <= pre_cnt_q + 9'h001;
      end
   end

   assign tick = run_q && (pre_cnt_q == PRESCALE_LAST[mode_q.prescale_select]);

   // ************************************************************
   // counter next value
   // ************************************************************

   // priority, lowest first: tick, capture action, software byte write
   always_comb begin
      count_d = count_q;
      ovf     = 1'b0;
      match   = 1'b0;
      if (tick) begin
         count_d = count_q + 16'h0001;
         if (count_q == COUNT_TOP) begin
            ovf = 1'b1;
            if (!cmp_mode_q && mode_q.reload_enable_bit
                && mode_q.reload_trigger_select == TRIG_OVERFLOW) begin
               count_d = reload_val;
            end
         end
         if (cmp_mode_q && count_q == reload_val) begin
            match = 1'b1;
            if (mode_q.match_clear_enable) begin
               count_d = COUNT_ZERO;
            end
         end
      end
      // capture actions belong to reload mode only
      if (!cmp_mode_q && |cap_event) begin
         if (mode_q.capture_clear_enable) begin
            count_d = COUNT_ZERO;
         end else if (mode_q.reload_enable_bit && mode_q.reload_trigger_select != TRIG_OVERFLOW
                      && cap_event[mode_q.reload_trigger_select - 2'd1]) begin
            count_d = reload_val;
         end
      end
      // software writes win; stop the counter first for a clean pair
      if (wr_en && req_q.idx == IDX_COUNT_LOW) begin
         count_d[7:0] = wb;
      end
      if (wr_en && req_q.idx == IDX_COUNT_HIGH) begin
         count_d[15:8] = wb;
      end
   end

   // counter flops
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         count_q <= COUNT_ZERO;
      end else begin
         count_q <= count_d;
      end
   end

   // ************************************************************
   // capture results
   // ************************************************************

   // each channel stores the count before any clear takes effect
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         for (int i = 0; i < NUM_CAP; i++) begin
            cap_q[i] <= COUNT_ZERO;
         end
      end else begin
         for (int i = 0; i < NUM_CAP; i++) begin
            if (cap_event[i]) begin
               cap_q[i] <= count_q;
            end
         end
      end
   end

   // ************************************************************
   // event flag, status and interrupt
   // ************************************************************

   // set wins over a clear in the same cycle; hardware never clears it
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         flag_q <= 1'b0;
      end else if (ovf || match) begin
         flag_q <= 1'b1;
      end else if (wr_en && req_q.idx == IDX_CONTROL) begin
         flag_q <= wb[CTL_FLAG_BIT];
      end else if (wr_en && req_q.idx == IDX_IRQ_STATUS && wb[ST_EVENT_BIT]) begin
         flag_q <= 1'b0;
      end
   end

   // capture status, write one to clear, new event wins
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         cap_st_q <= 3'b000;
      end else if (wr_en && req_q.idx == IDX_IRQ_STATUS) begin
         cap_st_q <= (cap_st_q & ~wb[ST_CAP_BIT +: NUM_CAP]) | cap_event;
      end else begin
         cap_st_q <= cap_st_q | cap_event;
      end
   end

   // level request gated by local and global enables
   assign irq = global_q && |({cap_st_q, flag_q} & mask_q);

   // ************************************************************
   // checks
   // ************************************************************
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_b);

   logic cnt_wr;
   assign cnt_wr = wr_en && (req_q.idx == IDX_COUNT_LOW || req_q.idx == IDX_COUNT_HIGH);

   stop_holds_a: assert property (!run_q && !cnt_wr && !(|cap_event) |=> $stable(count_q))
      else $error("count moved while stopped");
   prescale_gap_a: assert property (tick && mode_q.prescale_select == 3'b001
                                    |=> (!tick || mode_q.prescale_select != 3'b001) [*3])
      else $error("divide by four ticked early");
   overflow_flag_a: assert property (tick && count_q == COUNT_TOP |=> flag_q)
      else $error("overflow did not raise flag");
   flag_sticky_a: assert property (flag_q && !wr_en |=> flag_q)
      else $error("flag dropped without software");
   irq_gate_a: assert property (flag_q && mask_q[0] && global_q |-> irq)
      else $error("interrupt missing");
   reload_a: assert property (tick && count_q == COUNT_TOP && !cmp_mode_q && mode_q.reload_enable_bit
                              && mode_q.reload_trigger_select == TRIG_OVERFLOW && !cnt_wr && !(|cap_event)
                              |=> count_q == $past(reload_val))
      else $error("overflow reload wrong");
   no_reload_a: assert property (tick && count_q == COUNT_TOP && !mode_q.reload_enable_bit && !cnt_wr
                                 && !(|cap_event) && !match |=> count_q == COUNT_ZERO)
      else $error("reload while disabled");
   match_clear_a: assert property (tick && cmp_mode_q && count_q == reload_val && mode_q.match_clear_enable
                                   && !cnt_wr |=> count_q == COUNT_ZERO && flag_q)
      else $error("match clear wrong");
   capture_load_a: assert property (cap_event[0] |=> cap_q[0] == $past(count_q))
      else $error("capture did not store count");
   cap_clear_a: assert property (!cmp_mode_q && mode_q.capture_clear_enable && cap_event[1] && !cnt_wr
                                 |=> count_q == COUNT_ZERO)
      else $error("capture clear wrong");

   ovf_reload_c: cover property (ovf && mode_q.reload_enable_bit);
   match_c:      cover property (match ##1 flag_q);
   cap_clear_c:  cover property (|cap_event && mode_q.capture_clear_enable && !cmp_mode_q);
   irq_rise_c:   cover property ($rose(irq));

endmodule // up_counter_reload_compare

// [hdl/ctr_pkg.sv]
// Purpose: shared constants and types of the reload/compare up counter
// Assumes: register index times four is the bus byte address
// Notes:   all numbers of the block live here

package ctr_pkg;

   // ************************************************************
   // register indices (byte address = index * 4)
   // ************************************************************
   localparam logic [7:0] IDX_CONTROL    = 8'hc8; // counter_control
   localparam logic [7:0] IDX_MODE       = 8'hc9; // counter_mode_setup
   localparam logic [7:0] IDX_RCMP_LOW   = 8'hca; // reload_compare_low
   localparam logic [7:0] IDX_RCMP_HIGH  = 8'hcb; // reload_compare_high
   localparam logic [7:0] IDX_COUNT_LOW  = 8'hcc; // count_low_byte
   localparam logic [7:0] IDX_COUNT_HIGH = 8'hcd; // count_high_byte
   localparam logic [7:0] IDX_CAP_BASE   = 8'hd0; // capture results, low then high per channel
   localparam logic [7:0] IDX_IRQ_STATUS = 8'hd8; // sticky event bits, write one to clear
   localparam logic [7:0] IDX_IRQ_MASK   = 8'hd9; // local enables, same layout
   localparam logic [7:0] IDX_IRQ_GLOBAL = 8'hda; // global enable in bit 0

   // ************************************************************
   // field positions and reset values
   // ************************************************************
   localparam int unsigned CTL_FLAG_BIT = 7;     // counter_event_flag
   localparam int unsigned CTL_RUN_BIT  = 2;     // counter_run_bit
   localparam int unsigned CTL_MODE_BIT = 0;     // compare_reload_select
   localparam int unsigned ST_EVENT_BIT = 0;     // status bit mirroring the event flag
   localparam int unsigned ST_CAP_BIT   = 1;     // first capture status bit
   localparam int unsigned NUM_CAP      = 3;     // capture channels
   localparam logic [7:0]  RESET_BYTE   = 8'h00; // every register resets to zero
   localparam logic [15:0] COUNT_TOP    = 16'hffff;
   localparam logic [15:0] COUNT_ZERO   = 16'h0000;
   localparam logic [1:0]  TRIG_OVERFLOW = 2'b00;

   // prescaler terminal counts: ratio minus one for codes 000..111
   localparam logic [8:0] PRESCALE_LAST [0:7] = '{9'h000, 9'h003, 9'h00f, 9'h01f,
                                                  9'h03f, 9'h07f, 9'h0ff, 9'h1ff};

   // ************************************************************
   // carriers
   // ************************************************************
   typedef struct packed {
      logic       reload_enable_bit;     // bit 7
      logic [2:0] prescale_select;       // bits 6:4
      logic       capture_clear_enable;  // bit 3
      logic       match_clear_enable;    // bit 2
      logic [1:0] reload_trigger_select; // bits 1:0
   } mode_t;

   typedef struct packed {
      logic       valid; // a transfer was taken
      logic       wr;    // write when set
      logic       hit;   // address lies in the register window
      logic [7:0] idx;   // register index
   } bus_req_t;

endpackage

// [testbench/tb.sv]
// Purpose: self-checking bench of the reload/compare up counter
// Assumes: one wait state on reads, none on writes, hready tied to hreadyout
// Notes:   counts after the overflow and match runs are checked as ranges, the other stopped ones exactly
`timescale 1ns/10ps

module tb
   import ctr_pkg::*;
;

   // ************************************************************
   // signals
   // ************************************************************
   logic        sys_clk;            // 100 MHz system clock
   logic        rst_b;              // active low reset
   logic        hsel;               // slave select
   logic [31:0] haddr;              // byte address
   logic [1:0]  htrans;             // transfer type
   logic        hwrite;             // write strobe
   logic [2:0]  hsize;              // always a word
   logic [31:0] hwdata;             // write data
   logic        hready;             // bus ready, single slave
   logic [31:0] hrdata;             // read data
   logic        hreadyout;          // slave ready
   logic        hresp;              // response, checked okay on reads
   logic [2:0]  cap_event;          // capture pulses
   logic        irq;                // level interrupt
   int          n_fail;             // mismatches seen
   int          checks_done;        // comparisons made
   logic [31:0] exp_lo_q [$];       // expected floor per read
   logic [31:0] exp_hi_q [$];       // expected ceiling per read
   logic [31:0] lo_e;               // monitor copy of floor
   logic [31:0] hi_e;               // monitor copy of ceiling
   logic        rd_pend = 1'b0;     // read in its data phase
   logic [7:0]  rl;                 // random reload low byte
   logic [7:0]  rh;                 // random reload high byte
   logic [7:0]  vl;                 // random count low byte
   logic [7:0]  vh;                 // random count high byte
   int          ratios [8] = '{1, 4, 16, 32, 64, 128, 256, 512}; // divide ratio per code
   logic [7:0]  zregs [10] = '{IDX_CONTROL, IDX_MODE, IDX_RCMP_LOW, IDX_RCMP_HIGH, IDX_COUNT_LOW,
                                IDX_COUNT_HIGH, IDX_CAP_BASE, IDX_IRQ_STATUS, IDX_IRQ_MASK, 8'h20};

   assign hready = hreadyout;

   up_counter_reload_compare up_counter_reload_compare_inst (
      .sys_clk(sys_clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .cap_event(cap_event), .irq(irq));

   // free-running clock
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   // ************************************************************
   // checking and closing
   // ************************************************************
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_fail++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic final_report();
      if (exp_lo_q.size() != 0) begin
         n_fail++; // a noted read never came back
      end
      if (n_fail == 0 && checks_done > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // ************************************************************
   // bus master tasks
   // ************************************************************
   // bounded wait for hready at a rising edge; a hang ends the run
   task automatic wait_ready();
      int n;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (hready !== 1'b1 && n < 20);
      if (hready !== 1'b1) begin
         n_fail++;
         final_report();
      end
   endtask

   // one single word transfer, entered just after a rising edge
   task automatic xfer(input logic [7:0] idx, input logic wr_en, input logic [7:0] d);
      hsel   <= 1'b1;
      haddr  <= {22'h0, idx, 2'b00};
      htrans <= 2'b10;
      hwrite <= wr_en;
      wait_ready();
      htrans <= 2'b00;
      hwdata <= {24'h0, d};
      wait_ready();
   endtask

   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      xfer(idx, 1'b1, d);
   endtask

   // note the expected range, then read; the monitor compares
   task automatic rd(input logic [7:0] idx, input logic [7:0] lo, input logic [7:0] hi);
      exp_lo_q.push_back({24'h0, lo});
      exp_hi_q.push_back({24'h0, hi});
      xfer(idx, 1'b0, 8'h00);
   endtask

   task automatic rdx(input logic [7:0] idx, input logic [7:0] v);
      rd(idx, v, v);
   endtask

   // monitor: tracks data phases, takes read data when hready is high
   always @(posedge sys_clk) begin
      if (hready === 1'b1) begin
         if (rd_pend && exp_lo_q.size() > 0) begin
            lo_e = exp_lo_q.pop_front();
            hi_e = exp_hi_q.pop_front();
            check({31'h0, hresp}, 32'h0);
            if (lo_e === hi_e) begin
               check(hrdata, lo_e);
            end else begin
               check({31'h0, hrdata >= lo_e && hrdata <= hi_e}, 32'h1);
            end
         end
         rd_pend <= hsel && htrans[1] && !hwrite;
      end
   end

   // ************************************************************
   // main sequence
   // ************************************************************
   initial begin
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'b010;
      hwdata = 32'h0;
      cap_event = 3'b000;
      rst_b = 1'b0;
      n_fail = 0;
      checks_done = 0;
      void'($urandom(32'h64509c56));
      rl = 8'($urandom_range(0, 224));
      rh = 8'($urandom) | 8'h10;
      repeat (12) @(posedge sys_clk);
      rst_b <= 1'b1;
      @(posedge sys_clk);
      // reset values, unmapped place included
      foreach (zregs[i]) rdx(zregs[i], 8'h00);
      wr(IDX_RCMP_LOW, rl);
      wr(IDX_RCMP_HIGH, rh);
      wr(8'h20, rh);
      rdx(IDX_RCMP_LOW, rl);
      rdx(IDX_RCMP_HIGH, rh);
      rdx(8'h20, 8'h00);
      // every divide code: run four periods, stop, count stays put
      for (int k = 0; k < 8; k++) begin
         wr(IDX_COUNT_LOW, 8'h00);
         wr(IDX_COUNT_HIGH, 8'h00);
         wr(IDX_MODE, {1'b0, k[2:0], 4'h0});
         wr(IDX_CONTROL, 8'h04);
         repeat (4 * ratios[k]) @(posedge sys_clk);
         wr(IDX_CONTROL, 8'h00);
         repeat (10) @(posedge sys_clk);
         // run edge plus four periods plus the stop write: six ticks at divide 1, four otherwise
         rdx(IDX_COUNT_LOW, k == 0 ? 8'd6 : 8'd4);
         rdx(IDX_COUNT_HIGH, 8'h00);
      end
      // overflow from fffe, without and with reload
      wr(IDX_IRQ_MASK, 8'h01);
      wr(IDX_IRQ_GLOBAL, 8'h01);
      for (int e = 0; e < 2; e++) begin
         wr(IDX_IRQ_STATUS, 8'h01);
         wr(IDX_COUNT_LOW, 8'hfe);
         wr(IDX_COUNT_HIGH, 8'hff);
         wr(IDX_MODE, e ? 8'h80 : 8'h00);
         wr(IDX_CONTROL, 8'h04);
         repeat (7) @(posedge sys_clk);
         // flag seen while running; stop keeps bit 7 high since a zero there clears it
         rdx(IDX_CONTROL, 8'h84);
         wr(IDX_CONTROL, 8'h80);
         rd(IDX_COUNT_LOW, e ? rl + 8'd5 : 8'd5, e ? rl + 8'd12 : 8'd12);
         rdx(IDX_COUNT_HIGH, e ? rh : 8'h00);
         rdx(IDX_CONTROL, 8'h80);
         check({31'h0, irq}, 32'h1);
      end
      // flag stays until software clears it; irq needs both enables
      repeat (50) @(posedge sys_clk);
      rdx(IDX_CONTROL, 8'h80);
      for (int m = 0; m < 4; m++) begin
         wr(IDX_IRQ_MASK, {7'h0, m[0]});
         wr(IDX_IRQ_GLOBAL, {7'h0, m[1]});
         @(posedge sys_clk);
         check({31'h0, irq}, {31'h0, m == 3});
      end
      wr(IDX_CONTROL, 8'h00);
      rdx(IDX_IRQ_STATUS, 8'h00);
      // compare mode, match at 8, without and with match clear
      wr(IDX_RCMP_HIGH, 8'h00);
      wr(IDX_RCMP_LOW, 8'h08);
      for (int c = 0; c < 2; c++) begin
         wr(IDX_IRQ_STATUS, 8'h01);
         wr(IDX_COUNT_LOW, 8'h00);
         wr(IDX_COUNT_HIGH, 8'h00);
         wr(IDX_MODE, c ? 8'h04 : 8'h00);
         wr(IDX_CONTROL, 8'h05);
         repeat (17) @(posedge sys_clk);
         // match flag seen while running, then stop without clearing it
         rdx(IDX_CONTROL, 8'h85);
         wr(IDX_CONTROL, 8'h81);
         rd(IDX_COUNT_LOW, c ? 8'd0 : 8'd17, c ? 8'd8 : 8'd22);
         rdx(IDX_CONTROL, 8'h81);
      end
      // captures on a stopped count: reload, then clear without reload
      wr(IDX_CONTROL, 8'h00);
      wr(IDX_RCMP_HIGH, rh);
      for (int i = 0; i < 3; i++) begin
         for (int a = 0; a < 2; a++) begin
            vl = 8'($urandom);
            vh = 8'($urandom);
            wr(IDX_COUNT_LOW, vl);
            wr(IDX_COUNT_HIGH, vh);
            wr(IDX_MODE, {4'h8, a[0], 1'b0, 2'(i + 1)});
            cap_event <= 3'(1 << i);
            @(posedge sys_clk);
            cap_event <= 3'b000;
            @(posedge sys_clk);
            rdx(IDX_CAP_BASE + 8'(2 * i), vl);
            rdx(IDX_CAP_BASE + 8'(2 * i + 1), vh);
            rdx(IDX_COUNT_LOW, a ? 8'h00 : 8'h08);
            rdx(IDX_COUNT_HIGH, a ? 8'h00 : rh);
         end
      end
      // capture status bits raise and drop the interrupt
      rdx(IDX_IRQ_STATUS, 8'h0e);
      wr(IDX_IRQ_MASK, 8'h0e);
      @(posedge sys_clk);
      check({31'h0, irq}, 32'h1);
      wr(IDX_IRQ_STATUS, 8'h0e);
      @(posedge sys_clk);
      check({31'h0, irq}, 32'h0);
      final_report();
   end

endmodule // tb
